// *** rtl/ffs_defines.svh ***
// Constants of the flyback fault supervisor: clock, timing and thresholds.
`ifndef FFS_DEFINES_SVH
`define FFS_DEFINES_SVH

// ***********************************************************************
// Clock and times
// ***********************************************************************
`define FFS_CLK_HZ 40000000
`define FFS_CLK_MHZ 40
`define FFS_OPP_MS 160
`define FFS_REC_MS 1500
`define FFS_PROBE_US 10
`define FFS_CSF_LONG_NS 2000
`define FFS_CSF_SHORT_NS 1000
// Cycle counts; the kHz split keeps the products inside 32 bits.
`define FFS_OPP_CYC ((`FFS_CLK_HZ / 1000) * `FFS_OPP_MS)
`define FFS_REC_CYC ((`FFS_CLK_HZ / 1000) * `FFS_REC_MS)
`define FFS_PROBE_CYC (`FFS_PROBE_US * `FFS_CLK_MHZ)
`define FFS_CSF_LONG_CYC ((`FFS_CSF_LONG_NS * `FFS_CLK_MHZ) / 1000)
`define FFS_CSF_SHORT_CYC ((`FFS_CSF_SHORT_NS * `FFS_CLK_MHZ) / 1000)

// ***********************************************************************
// Pulse counts and levels
// ***********************************************************************
`define FFS_OTP_PULSES 3'd3
`define FFS_FLT_PULSES 3'd3
`define FFS_CLAMP_CODE 8'h50
`define FFS_CLAMP_RST 8'h00

`endif

// *** rtl/ffs_pkg.sv ***
// Types shared by the flyback fault supervisor modules.
`default_nettype none
package ffs_pkg;
    typedef enum logic [2:0] {
        FFS_OFF,
        FFS_PROBE,
        FFS_RUN,
        FFS_LOCKOUT,
        FFS_RECOVER
    } ffs_state_t;
    typedef logic [2:0] ffs_cnt_t;
endpackage : ffs_pkg
`default_nettype wire

// *** rtl/ffs_tmr_if.sv ***
// Control and status bundle between the supervisor and one long timer.
`default_nettype none
interface ffs_tmr_if #(parameter int W = 26);
    logic run;
    logic [W-1:0] limit;
    logic done;
    modport ctrl (output run, output limit, input done);
    modport tmr (input run, input limit, output done);
endinterface : ffs_tmr_if
`default_nettype wire

// *** rtl/ffs_timer.sv ***
// Long interval timer: counts while run is high, clears when it drops.
`default_nettype none
module ffs_timer #(
    parameter int W = 26
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    ffs_tmr_if.tmr tmr
);
    logic [W-1:0] cnt_q;
    logic done_q;
    wire at_end = (cnt_q == tmr.limit - W'(1));

    assign tmr.done = done_q;

    // Any break in run restarts the interval from zero.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !tmr.run) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (at_end) begin
            done_q <= 1'b1; // Holds until run drops.
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    AST_TMR_CLEAR: assert property (@(posedge core_clk_in) // see R17
        disable iff (!rst_n_in)
        !tmr.run |=> (cnt_q == '0) && !tmr.done)
        else $error("Timer did not clear when run dropped.");
endmodule : ffs_timer
`default_nettype wire

// *** rtl/ffs_supervisor.sv ***
// Fault supervision and restart sequencing of a flyback controller.
//
// What this block does
// R01 - Thermistor low for more than three gate pulses latches over-temperature.
// R02 - Latched over-temperature raises the reference; clears at a pulse end with pin high.
// R03 - With thermistor grounded, keep lockout cycling with three test pulses.
// R04 - Peak current over the over-power threshold starts a 160 ms timer.
// R05 - Unbroken 160 ms over-power stops switching and starts 1.5 s recovery.
// R06 - Commanded current-sense level is capped at 0.8 V always.
// R07 - At supply turn-off, high current or low aux sense starts recovery.
// R08 - Three windowed over-current pulses stop switching, drop run, recover.
// R09 - Recovery has no gate pulses; restart at turn-off after timeout.
// R10 - Junction over-temperature forces lockout, repeated while still set.
// R11 - First gate pulse on-time over its limit starts recovery.
// R12 - Three pulses at over-current level mean open sense pin: recover.
// R13 - Gate regulator pin low 10 us after turn-on forces lockout.
// R14 - Gate regulator over-voltage on three pulses forces lockout.
// R15 - Programming pin open or short at turn-on forces immediate lockout.
// R16 - Pulse counters clear on a clean pulse and at every restart.
// R17 - Long timers count the clock and clear at lockout.
`include "ffs_defines.svh"
`default_nettype none
module ffs_supervisor #(
    parameter int OPP_CYCLES = `FFS_OPP_CYC,
    parameter int REC_CYCLES = `FFS_REC_CYC,
    parameter int TW = 26
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic vdd_on_in,
    input wire logic vdd_off_in,
    input wire logic low_side_gate_pulse_in,
    input wire logic thermistor_pin_low_in,
    input wire logic cs_above_opp_in,
    input wire logic cs_at_ocp_in,
    input wire logic cs_ocp_window_in,
    input wire logic aux_winding_sense_pin_low_in,
    input wire logic junction_hot_in,
    input wire logic hv_gate_regulator_pin_low_in,
    input wire logic hv_gate_regulator_pin_ov_in,
    input wire logic [3:0] prog_pin_fault_in,
    input wire logic switch_type_sel_in,
    input wire logic magnetizing_time_program_pin_high_in,
    input wire logic [7:0] cs_demand_in,
    output logic switching_enable_out,
    output logic run_out,
    output logic thermistor_hi_ref_out,
    output logic [7:0] peak_current_clamp_out,
    output logic over_power_fault_out,
    output logic over_current_fault_out,
    output logic output_short_fault_out,
    output logic recovery_active_out,
    output logic lockout_active_out
);
    // *******************************************************************
    // Helpers
    // *******************************************************************
    // Consecutive-pulse count: saturating step, or zero on a clean pulse.
    function automatic ffs_pkg::ffs_cnt_t cnt_step(
        input ffs_pkg::ffs_cnt_t cnt, input logic cond);
        if (!cond) begin
            return '0;
        end
        return (cnt == 3'd7) ? cnt : cnt + 3'd1;
    endfunction : cnt_step

    ffs_pkg::ffs_state_t state_q, state_d;
    ffs_pkg::ffs_cnt_t otp_cnt_q, ocp_cnt_q, open_cnt_q, hvov_cnt_q;
    ffs_pkg::ffs_cnt_t otp_cnt_d, ocp_cnt_d, open_cnt_d, hvov_cnt_d;
    logic gate_prev_q, first_pulse_q, otp_q;
    logic [8:0] probe_cnt_q;
    logic [6:0] ontime_cnt_q;
    logic sw_en_q, run_q, opp_flt_q, ocp_flt_q, scp_flt_q, rec_q, lock_q;
    logic [7:0] clamp_q;

    ffs_tmr_if #(.W(TW)) opp_tmr ();
    ffs_tmr_if #(.W(TW)) rec_tmr ();

    // *******************************************************************
    // Event decode
    // *******************************************************************
    // Gate pulse ends on the falling edge; counters act only then.
    wire in_run = (state_q == ffs_pkg::FFS_RUN);
    wire in_probe = (state_q == ffs_pkg::FFS_PROBE);
    wire pulse_end = in_run && gate_prev_q && !low_side_gate_pulse_in;
    wire probe_done = (probe_cnt_q == 9'(`FFS_PROBE_CYC - 1));
    wire csf_long = switch_type_sel_in
        || magnetizing_time_program_pin_high_in;
    wire [6:0] csf_limit = csf_long ? 7'(`FFS_CSF_LONG_CYC)
        : 7'(`FFS_CSF_SHORT_CYC);

    // Next counts; the trips below read them so the third pulse acts.
    assign otp_cnt_d = cnt_step(otp_cnt_q, thermistor_pin_low_in);
    assign ocp_cnt_d = cnt_step(ocp_cnt_q, cs_ocp_window_in);
    assign open_cnt_d = cnt_step(open_cnt_q, cs_at_ocp_in);
    assign hvov_cnt_d = cnt_step(hvov_cnt_q, hv_gate_regulator_pin_ov_in);

    wire otp_trip = pulse_end && !otp_q
        && (otp_cnt_d > `FFS_OTP_PULSES); // see R01
    // While latched, stay stopped after three test pulses still low.
    wire otp_hold = pulse_end && otp_q
        && (otp_cnt_d >= `FFS_OTP_PULSES); // see R03
    wire otp_clear = pulse_end && otp_q && !thermistor_pin_low_in;
    wire ocp_trip = pulse_end && (ocp_cnt_d == `FFS_FLT_PULSES); // see R08
    wire open_trip = pulse_end
        && (open_cnt_d == `FFS_FLT_PULSES); // see R12
    wire hvov_trip = pulse_end
        && (hvov_cnt_d == `FFS_FLT_PULSES); // see R14
    wire short_trip = in_run && first_pulse_q && low_side_gate_pulse_in
        && (ontime_cnt_q >= csf_limit); // see R11
    wire scp_trip = in_run && vdd_off_in
        && (cs_above_opp_in || aux_winding_sense_pin_low_in); // see R07
    wire opp_trip = in_run && opp_tmr.done; // see R05

    wire to_recover = ocp_trip || open_trip || short_trip
        || scp_trip || opp_trip;
    wire to_lockout = otp_trip || otp_hold || hvov_trip
        || (in_run && (junction_hot_in || vdd_off_in)); // see R10

    // Long timers: over-power runs only while the level is unbroken.
    assign opp_tmr.run = in_run && cs_above_opp_in; // see R04
    assign opp_tmr.limit = TW'(OPP_CYCLES);
    assign rec_tmr.run = (state_q == ffs_pkg::FFS_RECOVER); // see R17
    assign rec_tmr.limit = TW'(REC_CYCLES);

    ffs_timer #(.W(TW)) u_opp_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tmr(opp_tmr)
    );
    ffs_timer #(.W(TW)) u_rec_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tmr(rec_tmr)
    );

    // *******************************************************************
    // Sequencer
    // *******************************************************************
    // Recovery outranks a plain lockout when both strike together.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ffs_pkg::FFS_OFF: begin
                if (vdd_on_in) begin
                    state_d = ffs_pkg::FFS_PROBE;
                end
            end
            ffs_pkg::FFS_PROBE: begin
                if (|prog_pin_fault_in || junction_hot_in) begin
                    state_d = ffs_pkg::FFS_LOCKOUT; // see R15
                end else if (probe_done) begin
                    state_d = hv_gate_regulator_pin_low_in
                        ? ffs_pkg::FFS_LOCKOUT // see R13
                        : ffs_pkg::FFS_RUN;
                end
            end
            ffs_pkg::FFS_RUN: begin
                if (to_recover) begin
                    state_d = ffs_pkg::FFS_RECOVER;
                end else if (to_lockout) begin
                    state_d = ffs_pkg::FFS_LOCKOUT;
                end
            end
            ffs_pkg::FFS_LOCKOUT: begin
                if (vdd_off_in) begin
                    state_d = ffs_pkg::FFS_OFF;
                end
            end
            ffs_pkg::FFS_RECOVER: begin
                if (vdd_off_in && rec_tmr.done) begin
                    state_d = ffs_pkg::FFS_OFF; // see R09
                end
            end
            default: begin
                state_d = ffs_pkg::FFS_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ffs_pkg::FFS_OFF;
            gate_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_prev_q <= low_side_gate_pulse_in;
        end
    end

    // Counters restart whenever the converter leaves the run state.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !in_run) begin
            otp_cnt_q <= '0; // see R16
            ocp_cnt_q <= '0;
            open_cnt_q <= '0;
            hvov_cnt_q <= '0;
        end else if (pulse_end) begin
            otp_cnt_q <= otp_cnt_d;
            ocp_cnt_q <= ocp_cnt_d;
            open_cnt_q <= open_cnt_d;
            hvov_cnt_q <= hvov_cnt_d;
        end
    end

    // Probe delay after turn-on and first-pulse on-time measurement.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !in_probe) begin
            probe_cnt_q <= '0;
        end else if (!probe_done) begin
            probe_cnt_q <= probe_cnt_q + 9'd1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !in_run) begin
            first_pulse_q <= 1'b1;
            ontime_cnt_q <= '0;
        end else if (pulse_end) begin
            first_pulse_q <= 1'b0; // Later pulses are not timed.
        end else if (first_pulse_q && low_side_gate_pulse_in) begin
            ontime_cnt_q <= ontime_cnt_q + 7'd1;
        end
    end

    // The latch survives lockout cycles; only a cool pin releases it.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            otp_q <= 1'b0;
        end else if (otp_trip) begin
            otp_q <= 1'b1; // see R01
        end else if (otp_clear) begin
            otp_q <= 1'b0; // see R02
        end
    end

    // *******************************************************************
    // Outputs
    // *******************************************************************
    // Fault flags are set in run and cleared at the next turn-on only.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sw_en_q <= 1'b0;
            run_q <= 1'b0;
            rec_q <= 1'b0;
            lock_q <= 1'b0;
            opp_flt_q <= 1'b0;
            ocp_flt_q <= 1'b0;
            scp_flt_q <= 1'b0;
            clamp_q <= `FFS_CLAMP_RST;
        end else begin
            sw_en_q <= (state_d == ffs_pkg::FFS_RUN);
            run_q <= (state_d == ffs_pkg::FFS_RUN) && !otp_q;
            rec_q <= (state_d == ffs_pkg::FFS_RECOVER);
            lock_q <= (state_d == ffs_pkg::FFS_LOCKOUT);
            opp_flt_q <= opp_trip || (opp_flt_q && !vdd_on_in);
            ocp_flt_q <= ocp_trip || (ocp_flt_q && !vdd_on_in);
            scp_flt_q <= scp_trip || (scp_flt_q && !vdd_on_in);
            clamp_q <= (cs_demand_in > `FFS_CLAMP_CODE)
                ? `FFS_CLAMP_CODE : cs_demand_in; // see R06
        end
    end

    assign switching_enable_out = sw_en_q;
    assign run_out = run_q;
    assign thermistor_hi_ref_out = otp_q;
    assign peak_current_clamp_out = clamp_q;
    assign over_power_fault_out = opp_flt_q;
    assign over_current_fault_out = ocp_flt_q;
    assign output_short_fault_out = scp_flt_q;
    assign recovery_active_out = rec_q;
    assign lockout_active_out = lock_q;

    // *******************************************************************
    // Checks
    // *******************************************************************
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_OTP_FOURTH: assert property ( // see R01
        $rose(otp_q) |-> $past(otp_cnt_q) == 3'd3)
        else $error("Over-temperature latched on the wrong pulse.");
    AST_OTP_RELEASE: assert property ( // see R02
        $fell(otp_q) |-> $past(pulse_end && !thermistor_pin_low_in))
        else $error("Over-temperature released without a cool pulse.");
    AST_OTP_RETEST: assert property ( // see R03
        in_run && otp_q && pulse_end && otp_cnt_q == 3'd2
        && thermistor_pin_low_in && !to_recover
        |=> state_q == ffs_pkg::FFS_LOCKOUT)
        else $error("Grounded thermistor did not end the test burst.");
    AST_OPP_BREAK: assert property ( // see R05
        in_run && !cs_above_opp_in |=> !opp_tmr.done)
        else $error("Over-power timing survived an interruption.");
    AST_CLAMP: assert property ( // see R06
        ##1 peak_current_clamp_out <= `FFS_CLAMP_CODE)
        else $error("Current-sense command exceeds the clamp.");
    AST_SCP: assert property ( // see R07
        scp_trip |=> recovery_active_out && output_short_fault_out)
        else $error("Short at turn-off did not start recovery.");
    AST_OCP: assert property ( // see R08
        in_run && pulse_end && ocp_cnt_q == 3'd2 && cs_ocp_window_in
        |=> !run_out && !switching_enable_out && recovery_active_out)
        else $error("Third over-current pulse did not stop switching.");
    AST_REC_QUIET: assert property ( // see R09
        state_q == ffs_pkg::FFS_RECOVER && !rec_tmr.done
        |=> state_q == ffs_pkg::FFS_RECOVER && !switching_enable_out)
        else $error("Recovery left early or switched.");
    AST_HV_PROBE: assert property ( // see R13
        in_probe && probe_done && hv_gate_regulator_pin_low_in
        |=> lockout_active_out ##0 !switching_enable_out)
        else $error("Low gate regulator pin did not force lockout.");
    AST_PROG_PINS: assert property ( // see R15
        in_probe && |prog_pin_fault_in |=> lockout_active_out)
        else $error("Programming pin fault not acted on at once.");
    AST_CNT_CLEAR: assert property ( // see R16
        !in_run |=> otp_cnt_q == 3'd0 && ocp_cnt_q == 3'd0
        && open_cnt_q == 3'd0 && hvov_cnt_q == 3'd0)
        else $error("Pulse counters not cleared outside run.");

    COV_OTP: cover property ($rose(otp_q));
    COV_OCP_RECOVER: cover property (ocp_trip ##1 recovery_active_out);
    COV_RESTART: cover property (
        state_q == ffs_pkg::FFS_RECOVER ##1 state_q == ffs_pkg::FFS_OFF);
    COV_OPP: cover property (opp_trip);
endmodule : ffs_supervisor
`default_nettype wire

// *** test/ffs_stage_model.sv ***
// Power stage stand-in that fires low-side gate pulses on request.
`default_nettype none
module ffs_stage_model (
    input wire logic core_clk_in,
    input wire logic switching_enable_in,
    input wire logic fire_in,
    input wire logic [7:0] on_cycles_in,
    output logic gate_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int i;
    // ****************************************
    // Pulse generator
    // ****************************************
    // A request is taken at a rising edge and busy marks it until done.
    // The gate only moves on falling edges so the supervisor samples it
    // cleanly; a disabled driver cuts the pulse at once, as a real one would.
    initial begin
        gate_out = 1'b0;
        busy_out = 1'b0;
        forever begin
            @(posedge core_clk_in);
            if (fire_in) begin
                busy_out = 1'b1;
                @(negedge core_clk_in);
                gate_out = switching_enable_in;
                for (i = 0; i < on_cycles_in; i++) begin
                    @(negedge core_clk_in);
                    gate_out = gate_out & switching_enable_in;
                end
                gate_out = 1'b0;
                repeat (4) @(negedge core_clk_in);
                @(posedge core_clk_in);
                busy_out = 1'b0;
            end
        end
    end
endmodule : ffs_stage_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the flyback fault supervisor.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals and expectations
    // ****************************************
    // Short timer counts keep the run brief; expectations use them too.
    localparam int OPP_C = 50;
    localparam int REC_C = 100;
    localparam logic [7:0] M_EN = 8'h01;
    localparam logic [7:0] M_RUN = 8'h02;
    localparam logic [7:0] M_HREF = 8'h04;
    localparam logic [7:0] M_OPF = 8'h08;
    localparam logic [7:0] M_OCF = 8'h10;
    localparam logic [7:0] M_SCF = 8'h20;
    localparam logic [7:0] M_REC = 8'h40;
    localparam logic [7:0] M_LCK = 8'h80;
    localparam logic [7:0] M_SEQ = 8'hc3;
    logic core_clk_in, rst_n_in, vdd_on, vdd_off, therm, cs_opp, cs_ocp;
    logic cs_win, aux_low, hot, hv_low, hv_ov, sel, res, fire;
    logic sw_en, run, href, opf, ocf, scf, rec, lck, gate, busy;
    logic [3:0] prog;
    logic [7:0] demand, on_cyc, clamp, st, ex;
    logic [7:0] wd [6] = '{8'h46, 8'h5a, 8'h46, 8'h5a, 8'h23, 8'h2d};
    logic [5:0] sel_t = 6'b000011;
    logic [5:0] res_t = 6'b001100;
    logic [5:0] trip_t = 6'b101010;
    int mismatches, checks_done, cycles, k;
    // Status byte gathers every one-bit output for a single compare.
    assign st = {lck, rec, scf, ocf, opf, href, run, sw_en};

    ffs_supervisor #(.OPP_CYCLES(OPP_C), .REC_CYCLES(REC_C)) ffs_supervisor_i (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .vdd_on_in(vdd_on), .vdd_off_in(vdd_off),
        .low_side_gate_pulse_in(gate), .thermistor_pin_low_in(therm),
        .cs_above_opp_in(cs_opp), .cs_at_ocp_in(cs_ocp),
        .cs_ocp_window_in(cs_win), .aux_winding_sense_pin_low_in(aux_low),
        .junction_hot_in(hot), .hv_gate_regulator_pin_low_in(hv_low),
        .hv_gate_regulator_pin_ov_in(hv_ov), .prog_pin_fault_in(prog),
        .switch_type_sel_in(sel), .magnetizing_time_program_pin_high_in(res),
        .cs_demand_in(demand), .switching_enable_out(sw_en), .run_out(run),
        .thermistor_hi_ref_out(href), .peak_current_clamp_out(clamp),
        .over_power_fault_out(opf), .over_current_fault_out(ocf),
        .output_short_fault_out(scf), .recovery_active_out(rec),
        .lockout_active_out(lck));

    ffs_stage_model ffs_stage_model_i (
        .core_clk_in(core_clk_in), .switching_enable_in(sw_en),
        .fire_in(fire), .on_cycles_in(on_cyc), .gate_out(gate),
        .busy_out(busy));

    // ****************************************
    // Clock, timeout and tasks
    // ****************************************
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    // The ceiling sits well above the roughly 11400 cycles the run needs.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One gate pulse of w high cycles, waiting for the stage to go idle.
    task automatic pulse(input logic [7:0] w);
        int j;
        @(negedge core_clk_in);
        on_cyc = w;
        fire = 1'b1;
        for (j = 0; j < 400 && busy !== 1'b1; j++) @(negedge core_clk_in);
        fire = 1'b0;
        for (j = 0; j < 400 && busy !== 1'b0; j++) @(negedge core_clk_in);
    endtask : pulse

    task automatic pulses(input int n);
        repeat (n) pulse(8'h0a);
    endtask : pulses

    task automatic off_tick();
        @(negedge core_clk_in);
        vdd_off = 1'b1;
        @(negedge core_clk_in);
        vdd_off = 1'b0;
        @(negedge core_clk_in);
    endtask : off_tick

    // Turn-on, then the probe window must hold switching off to its end.
    task automatic start(input logic [7:0] e);
        @(negedge core_clk_in);
        vdd_on = 1'b1;
        @(negedge core_clk_in);
        vdd_on = 1'b0;
        // The probe ends at the 400th edge after turn-on is taken, so the
        // last quiet sample sits one cycle before switching is allowed.
        repeat (399) @(negedge core_clk_in);
        chk(st & M_EN, 8'h00);
        @(negedge core_clk_in);
        chk(st, e);
    endtask : start

    task automatic leave_rec(input logic [7:0] m, input logic [7:0] e);
        repeat (REC_C + 10) @(negedge core_clk_in);
        off_tick();
        chk(st & m, e);
    endtask : leave_rec

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {rst_n_in, vdd_on, vdd_off, therm, cs_opp, cs_ocp, cs_win} = '0;
        {aux_low, hot, hv_low, hv_ov, sel, res, fire} = '0;
        {prog, demand, on_cyc} = '0;
        repeat (20) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        chk(st, 8'h00);
        start(M_EN | M_RUN);
        // Clamp table: below and above the 0.8 V code.
        foreach (wd[k]) begin
            demand = wd[k] + 8'h20;
            ex = (demand > 8'h50) ? 8'h50 : demand;
            repeat (2) @(negedge core_clk_in);
            chk(clamp, ex);
        end
        // Over-current count broken by a clean pulse, then three in a row.
        cs_win = 1'b1;
        pulses(2);
        cs_win = 1'b0;
        pulses(1);
        cs_win = 1'b1;
        pulses(2);
        chk(st, M_EN | M_RUN);
        pulses(1);
        chk(st, M_REC | M_OCF);
        cs_win = 1'b0;
        pulses(1);
        off_tick();
        chk(st, M_REC | M_OCF);
        leave_rec(8'hff, M_OCF);
        // Open sense pin.
        start(M_EN | M_RUN);
        cs_ocp = 1'b1;
        pulses(3);
        chk(st & M_SEQ, M_REC);
        cs_ocp = 1'b0;
        leave_rec(M_SEQ, 8'h00);
        // Regulator over-voltage on three pulses.
        start(M_EN | M_RUN);
        hv_ov = 1'b1;
        pulses(2);
        chk(st, M_EN | M_RUN);
        pulses(1);
        chk(st & M_SEQ, M_LCK);
        hv_ov = 1'b0;
        off_tick();
        // Over-power: an interrupted stretch, then an unbroken one.
        start(M_EN | M_RUN);
        cs_opp = 1'b1;
        repeat (40) @(negedge core_clk_in);
        cs_opp = 1'b0;
        @(negedge core_clk_in);
        cs_opp = 1'b1;
        repeat (40) @(negedge core_clk_in);
        chk(st, M_EN | M_RUN);
        repeat (15) @(negedge core_clk_in);
        chk(st, M_REC | M_OPF);
        cs_opp = 1'b0;
        leave_rec(8'hff, M_OPF);
        // Turn-off with low aux sense, then with high current.
        for (k = 0; k < 2; k++) begin
            start(M_EN | M_RUN);
            aux_low = (k == 0);
            cs_opp = (k == 1);
            off_tick();
            chk(st, M_REC | M_SCF);
            {aux_low, cs_opp} = '0;
            leave_rec(8'hff, M_SCF);
        end
        start(M_EN | M_RUN);
        off_tick();
        chk(st, M_LCK);
        off_tick();
        // Junction hot in run, and still hot at the next turn-on.
        start(M_EN | M_RUN);
        hot = 1'b1;
        repeat (2) @(negedge core_clk_in);
        chk(st, M_LCK);
        off_tick();
        start(M_LCK);
        hot = 1'b0;
        off_tick();
        // Every programming pin probe, then the regulator pin low.
        for (k = 0; k < 4; k++) begin
            prog = 4'h1 << k;
            start(M_LCK);
            off_tick();
        end
        prog = 4'h0;
        hv_low = 1'b1;
        start(M_LCK);
        off_tick();
        hv_low = 1'b0;
        // First pulse on-time limits; later long pulses are not checked.
        for (k = 0; k < 6; k++) begin
            sel = sel_t[k];
            res = res_t[k];
            start(M_EN | M_RUN);
            pulse(wd[k]);
            chk(st & M_SEQ, trip_t[k] ? M_REC : M_EN | M_RUN);
            if (trip_t[k]) leave_rec(M_SEQ, 8'h00);
            else begin
                pulse(8'h5a);
                chk(st & M_SEQ, M_EN | M_RUN);
                off_tick();
                off_tick();
            end
        end
        // Thermistor trip forces lockout; while latched a restart runs only
        // a three-pulse test burst, and one cool pulse releases the latch.
        start(M_EN | M_RUN);
        therm = 1'b1;
        pulses(3);
        chk(st, M_EN | M_RUN);
        pulses(1);
        chk(st, M_LCK | M_HREF);
        off_tick();
        start(M_EN | M_HREF);
        pulses(2);
        chk(st, M_EN | M_HREF);
        pulses(1);
        chk(st, M_LCK | M_HREF);
        off_tick();
        therm = 1'b0;
        start(M_EN | M_HREF);
        pulses(1);
        chk(st, M_EN | M_RUN);
        off_tick();
        off_tick();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
